// *** sfb_pkg.sv ***
// Package for the status flags and bank select register block
package sfb_pkg;
	// Register index; the bus byte address is four times this
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0003;
	localparam logic [8:0]  DADDR_STATUS = 9'h003;
	localparam logic [6:0]  DADDR_LOW_MASK = 7'h7f;
	localparam int BIT_INDIRECT_BANK = 7;
	localparam int BIT_BANK_HIGH = 6;
	localparam int BIT_BANK_LOW = 5;
	localparam int BIT_TIMEOUT = 4;
	localparam int BIT_POWERDOWN = 3;
	localparam int BIT_Z = 2;
	localparam int BIT_DIGIT_CARRY = 1;
	localparam int BIT_C = 0;
	localparam logic [7:0] RESET_STATUS = 8'h18;
	localparam logic [7:0] WRITE_MASK = 8'he7;
	localparam logic [7:0] FLAG_MASK = 8'h07;

	typedef enum logic [5:0] {
		SFB_OP_NONE = 6'h01,
		SFB_OP_ADD  = 6'h02,
		SFB_OP_SUB  = 6'h04,
		SFB_OP_LOGIC = 6'h08,
		SFB_OP_ROTR = 6'h10,
		SFB_OP_ROTL = 6'h20
	} sfb_op_e;

	typedef struct packed {
		logic [7:0] value;
	} sfb_state_s;

	typedef struct packed {
		logic [7:0] result;
		logic       zero;
		logic       digit_carry;
		logic       carry;
	} sfb_alu_s;
endpackage

// *** sfb_alu_flags.sv ***
// Flag generation for add, subtract, logic and rotate operations
`timescale 1ns/1ps
module sfb_alu_flags (
	input  wire logic           [7:0] op_a,
	input  wire logic           [7:0] op_b,
	input  wire logic                 carry_in,
	input  wire sfb_pkg::sfb_op_e     op,
	output sfb_pkg::sfb_alu_s         alu
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] opb_eff;
	logic       sub_cin;

	always_comb begin
		// Two's complement add
		// The +1 enters as carry in, so no carry out of bit 3 or 7 is lost
		sub_cin = (op == sfb_pkg::SFB_OP_SUB);
		opb_eff = sub_cin ? ~op_b : op_b;
		sum = {1'b0, op_a} + {1'b0, opb_eff} + {8'h00, sub_cin};
		nib = {1'b0, op_a[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, sub_cin};
		alu.result = op_a;
		alu.carry = carry_in;
		alu.digit_carry = 1'b0;
		case (op)
			sfb_pkg::SFB_OP_ADD, sfb_pkg::SFB_OP_SUB: begin
				// Carry from bit 7; borrow reads as zero
				alu.result = sum[7:0];
				alu.carry = sum[8];
				// Digit carry out of bit 3
				alu.digit_carry = nib[4];
			end
			sfb_pkg::SFB_OP_ROTR: begin
				alu.result = {carry_in, op_a[7:1]};
				alu.carry = op_a[0];
			end
			sfb_pkg::SFB_OP_ROTL: begin
				alu.result = {op_a[6:0], carry_in};
				alu.carry = op_a[7];
			end
			default: begin
				alu.result = op_a;
			end
		endcase
		alu.zero = (alu.result == 8'h00);
	end
endmodule // sfb_alu_flags

// *** sfb_status_bank.sv ***
// Status flags and bank select register with APB access and ALU update
`timescale 1ns/1ps
module sfb_status_bank (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic       [31:0] paddr,
	input  wire logic       [31:0] pwdata,
	input  wire logic       [3:0]  pstrb,
	output logic            [31:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              core_wr,
	input  wire logic       [8:0]  core_waddr,
	input  wire logic       [7:0]  core_wdata,
	input  wire sfb_pkg::sfb_op_e  alu_op,
	input  wire logic       [7:0]  alu_a,
	input  wire logic       [7:0]  alu_b,
	input  wire logic              watchdog_clear_instr,
	input  wire logic              sleep_instr,
	input  wire logic              watchdog_timeout,
	input  wire logic       [6:0]  direct_addr,
	input  wire logic       [7:0]  indirect_addr,
	output logic            [8:0]  direct_full_addr,
	output logic            [8:0]  indirect_full_addr,
	output logic            [7:0]  alu_result,
	output logic            [7:0]  status_flags_bank,
	output logic                   indirect_bank_select,
	output logic                   direct_bank_high,
	output logic                   direct_bank_low,
	output logic                   timeout_flag,
	output logic                   powerdown_flag,
	output logic                   digit_carry_flag,
	output logic                   zero_flag,
	output logic                   carry_flag
);
	sfb_pkg::sfb_state_s st;
	sfb_pkg::sfb_state_s next_st;
	sfb_pkg::sfb_alu_s   alu;
	logic                apb_hit;
	logic                apb_wr;
	logic                core_hit;
	logic                flag_op;
	logic          [7:0] wr_val;
	logic                wr_any;

	sfb_alu_flags u_alu (
		.op_a     (alu_a),
		.op_b     (alu_b),
		.carry_in (st.value[sfb_pkg::BIT_C]),
		.op       (alu_op),
		.alu      (alu)
	);

	// Register index scaled to a word-aligned byte address
	assign apb_hit = (paddr == {sfb_pkg::ADDR_STATUS[29:0], 2'b00});
	assign apb_wr = psel && penable && pwrite && apb_hit && pstrb[0];
	assign core_hit = core_wr &&
		(core_waddr[6:0] == sfb_pkg::DADDR_STATUS[6:0]);
	assign flag_op = (alu_op != sfb_pkg::SFB_OP_NONE);

	always_comb begin
		next_st = st;
		wr_any = core_hit || apb_wr;
		wr_val = core_hit ? core_wdata : pwdata[7:0];
		if (wr_any) begin
			next_st.value = (st.value & ~sfb_pkg::WRITE_MASK) |
				(wr_val & sfb_pkg::WRITE_MASK);
		end
		if (flag_op) begin
			// ALU owns flag bits
			// Write to all three flags is dropped, even those the op keeps
			next_st.value = (next_st.value & ~sfb_pkg::FLAG_MASK) |
				(st.value & sfb_pkg::FLAG_MASK);
			next_st.value[sfb_pkg::BIT_Z] = alu.zero;
			if (alu_op == sfb_pkg::SFB_OP_ADD ||
					alu_op == sfb_pkg::SFB_OP_SUB) begin
				next_st.value[sfb_pkg::BIT_DIGIT_CARRY] = alu.digit_carry;
			end
			if (alu_op != sfb_pkg::SFB_OP_LOGIC) begin
				next_st.value[sfb_pkg::BIT_C] = alu.carry;
			end
		end
		if (watchdog_timeout) begin
			next_st.value[sfb_pkg::BIT_TIMEOUT] = 1'b0;
		end
		if (watchdog_clear_instr || sleep_instr) begin
			next_st.value[sfb_pkg::BIT_TIMEOUT] = 1'b1;
		end
		if (sleep_instr) begin
			next_st.value[sfb_pkg::BIT_POWERDOWN] = 1'b0;
		end
		if (watchdog_clear_instr) begin
			next_st.value[sfb_pkg::BIT_POWERDOWN] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st.value <= sfb_pkg::RESET_STATUS;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite && apb_hit) begin
			prdata = {24'h00_0000, st.value};
		end
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_hit;

	assign direct_full_addr = {st.value[sfb_pkg::BIT_BANK_HIGH],
		st.value[sfb_pkg::BIT_BANK_LOW],
		direct_addr & sfb_pkg::DADDR_LOW_MASK};
	assign indirect_full_addr = {st.value[sfb_pkg::BIT_INDIRECT_BANK],
		indirect_addr};
	assign alu_result = alu.result;
	assign status_flags_bank = st.value;
	assign indirect_bank_select = st.value[sfb_pkg::BIT_INDIRECT_BANK];
	assign direct_bank_high = st.value[sfb_pkg::BIT_BANK_HIGH];
	assign direct_bank_low = st.value[sfb_pkg::BIT_BANK_LOW];
	assign timeout_flag = st.value[sfb_pkg::BIT_TIMEOUT];
	assign powerdown_flag = st.value[sfb_pkg::BIT_POWERDOWN];
	assign zero_flag = st.value[sfb_pkg::BIT_Z];
	assign digit_carry_flag = st.value[sfb_pkg::BIT_DIGIT_CARRY];
	assign carry_flag = st.value[sfb_pkg::BIT_C];

	AST_TIMEOUT_SLEEP: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		sleep_instr |=> timeout_flag && !powerdown_flag)
		else $error("sleep did not set time-out and clear power-down");
	AST_TIMEOUT_EXPIRY: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		watchdog_timeout && !watchdog_clear_instr && !sleep_instr
		|=> !timeout_flag)
		else $error("watchdog time-out did not clear flag");
	AST_CLR: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		watchdog_clear_instr |=> timeout_flag && powerdown_flag)
		else $error("watchdog clear did not set flags");
	AST_PROTECT: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		!watchdog_clear_instr && !sleep_instr && !watchdog_timeout
		|=> $stable({timeout_flag, powerdown_flag}))
		else $error("protected flags changed without event");
	AST_ADD_CARRY: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		alu_op == sfb_pkg::SFB_OP_ADD |=>
		carry_flag == ({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} > 9'h0ff))
		else $error("add carry wrong");
	AST_SUB_BORROW: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		alu_op == sfb_pkg::SFB_OP_SUB |=>
		carry_flag == ($past(alu_a) >= $past(alu_b)))
		else $error("subtract borrow polarity wrong");
	AST_ROTATE_RIGHT: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		alu_op == sfb_pkg::SFB_OP_ROTR |=> carry_flag == $past(alu_a[0]))
		else $error("rotate right carry wrong");
	AST_ZERO: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		flag_op |=> zero_flag == ($past(alu.result) == 8'h00))
		else $error("zero flag wrong");
	AST_MIRROR: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		core_wr && core_waddr == 9'h183 && !flag_op |=>
		direct_bank_high == $past(core_wdata[6]))
		else $error("mirror write missed");
	AST_INDIRECT: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		indirect_full_addr[8] == indirect_bank_select)
		else $error("indirect bank bit wrong");
	AST_FLAG_WRITE_DROP: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		flag_op && alu_op != sfb_pkg::SFB_OP_ADD &&
		alu_op != sfb_pkg::SFB_OP_SUB |=>
		digit_carry_flag == $past(digit_carry_flag))
		else $error("write reached digit carry during flag op");

	COV_SLEEP: cover property (@(posedge ref_clk) disable iff (!rstn)
		sleep_instr ##1 watchdog_timeout);
	COV_SUB: cover property (@(posedge ref_clk) disable iff (!rstn)
		alu_op == sfb_pkg::SFB_OP_SUB && core_hit);
	COV_APB: cover property (@(posedge ref_clk) disable iff (!rstn)
		apb_wr ##1 direct_bank_high);
endmodule // sfb_status_bank

// *** sfb_core_model.sv ***
// Behavioural core issuing one instruction per call
`timescale 1ns/1ps
module sfb_core_model (
	input  wire logic        ref_clk,
	input  wire logic [7:0]  alu_result,
	output logic             core_wr,
	output logic [8:0]       core_waddr,
	output logic [7:0]       core_wdata,
	output sfb_pkg::sfb_op_e alu_op,
	output logic [7:0]       alu_a,
	output logic [7:0]       alu_b,
	output logic [2:0]       events
);
	logic [7:0] res_seen;

	initial begin
		{core_wr, core_waddr, core_wdata, alu_a, alu_b, events} = '0;
		alu_op = sfb_pkg::SFB_OP_NONE;
		res_seen = 8'h00;
	end
	// Idle operands are inverted so stale values cannot pass for good ones
	task automatic exec(input sfb_pkg::sfb_op_e op, input logic [7:0] a, b,
		input logic wr, input logic [8:0] wa, input logic [7:0] wd,
		input logic [2:0] ev);
		@(posedge ref_clk);
		alu_op <= op;
		{core_wr, core_waddr, core_wdata} <= {wr, wa, wd};
		{alu_a, alu_b, events} <= {a, b, ev};
		@(posedge ref_clk);
		res_seen = alu_result;
		alu_op <= sfb_pkg::SFB_OP_NONE;
		{core_wr, alu_a, alu_b, events} <= {1'b0, ~a, ~b, 3'h0};
	endtask
endmodule // sfb_core_model

// *** status_flags_bank_select_bench.sv ***
// Self-checking bench for the status flags and bank select register
`timescale 1ns/1ps
module status_flags_bank_select_bench;
	logic             ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic             er, core_wr;
	logic [31:0]      paddr, pwdata, prdata, rd;
	logic [3:0]       pstrb;
	logic [2:0]       ev, x;
	logic [8:0]       dfa, ifa, waddr;
	logic [7:0]       wdata, alu_a, alu_b, alu_result, status, bits, st, w, a;
	logic [7:0]       indirect_addr;
	logic [6:0]       direct_addr;
	logic [10:0]      e;
	sfb_pkg::sfb_op_e alu_op, op;
	sfb_pkg::sfb_op_e ops [5];
	int               bad_count, total_checks, seed;

	sfb_status_bank i_sfb_status_bank (.ref_clk(ref_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_wr(core_wr), .core_waddr(waddr),
		.core_wdata(wdata), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
		.watchdog_clear_instr(ev[2]), .sleep_instr(ev[1]),
		.watchdog_timeout(ev[0]), .direct_addr(direct_addr),
		.indirect_addr(indirect_addr), .direct_full_addr(dfa),
		.indirect_full_addr(ifa), .alu_result(alu_result),
		.status_flags_bank(status), .indirect_bank_select(bits[7]),
		.direct_bank_high(bits[6]), .direct_bank_low(bits[5]),
		.timeout_flag(bits[4]), .powerdown_flag(bits[3]),
		.zero_flag(bits[2]), .digit_carry_flag(bits[1]),
		.carry_flag(bits[0]));
	sfb_core_model i_sfb_core_model (.ref_clk(ref_clk),
		.alu_result(alu_result), .core_wr(core_wr), .core_waddr(waddr),
		.core_wdata(wdata), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
		.events(ev));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) {direct_addr, indirect_addr} <= 15'($random(seed));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h want %h", $time, m, seen, exp);
		end
	endtask
	task automatic chk_st(input logic [7:0] m);
		chk(status & m, st & m, "register");
		chk(bits & m, st & m, "flag bits");
		chk(dfa, {st[6:5], 7'h00} + direct_addr, "direct");
		chk(ifa, {st[7], 8'h00} + indirect_addr, "indirect");
	endtask
	task automatic apb(input logic wr, input logic [31:0] ad, d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		for (int n = 0; n < 16 && pready !== 1'b1; n++) @(posedge ref_clk);
		if (pready !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	function automatic logic [10:0] alu_exp(input sfb_pkg::sfb_op_e o,
		input logic [7:0] p, q, c);
		logic [8:0] s;
		logic [4:0] h;
		logic       sb;
		sb = (o == sfb_pkg::SFB_OP_SUB);
		q = sb ? ~q : q;
		s = {1'b0, p} + {1'b0, q} + {8'h00, sb};
		h = {1'b0, p[3:0]} + {1'b0, q[3:0]} + {4'h0, sb};
		if (o == sfb_pkg::SFB_OP_ROTR) s = {p[0], c[0], p[7:1]};
		if (o == sfb_pkg::SFB_OP_ROTL) s = {p[7], p[6:0], c[0]};
		if (o == sfb_pkg::SFB_OP_LOGIC) s = {c[0], p};
		if (!(o inside {sfb_pkg::SFB_OP_ADD, sfb_pkg::SFB_OP_SUB})) h[4] = c[1];
		return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
	endfunction

	initial begin
		seed = 32'hd43cacf3;
		{rstn, psel, penable, pwrite, paddr, pwdata, rd, er} = '0;
		{direct_addr, indirect_addr} = 15'h0000;
		pstrb = 4'hf;
		ops = '{sfb_pkg::SFB_OP_LOGIC, sfb_pkg::SFB_OP_ADD,
			sfb_pkg::SFB_OP_SUB, sfb_pkg::SFB_OP_ROTR, sfb_pkg::SFB_OP_ROTL};
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		st = 8'h18;
		#1 chk_st(8'hff);
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? 8'h00 : 8'($random(seed));
			apb(1'b1, 32'hc, {24'h0, w});
			st = (w & 8'he7) | (st & 8'h18);
			#1 chk_st(8'hff);
			apb(1'b0, 32'hc, 32'h0);
			chk(rd, {24'h0, st}, "apb read");
		end
		apb(1'b1, 32'h83, 32'hff);
		chk(er, 1'b1, "unmapped error");
		apb(1'b0, 32'h4, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
		#1 chk_st(8'hff);
		$display("apb test done");
		for (int k = 0; k < 5; k++) begin
			w = {k[0], k[1:0], 5'($random(seed))};
			i_sfb_core_model.exec(sfb_pkg::SFB_OP_NONE, 8'h00, 8'h00, 1'b1,
				(k == 4) ? 9'h004 : {k[1:0], 7'h03}, w, 3'h0);
			if (k < 4) st = (w & 8'he7) | (st & 8'h18);
			#1 chk_st(8'hff);
		end
		for (int k = 0; k < 5; k++) begin
			x = 3'(15'b011100001010001 >> (3 * k));
			i_sfb_core_model.exec(sfb_pkg::SFB_OP_NONE, 8'h00, 8'h00, 1'b0,
				9'h000, 8'h00, x);
			if (x[2]) st[4:3] = 2'b11;
			else if (x[1]) st[4:3] = 2'b10;
			else st[4] = 1'b0;
			#1 chk_st(8'hff);
		end
		apb(1'b1, 32'hc, 32'hff);
		st = 8'he7 | (st & 8'h18);
		#1 chk_st(8'hff);
		$display("core write and event test done");
		for (int i = 0; i < 40; i++) begin
			op = ops[i % 5];
			{a, w} = 16'($random(seed));
			if (i == 1) {a, w} = 16'hff01;
			if (i == 2) {a, w} = 16'h5a5a;
			if (i == 7) {a, w} = 16'h0001;
			e = alu_exp(op, a, w, st);
			i_sfb_core_model.exec(op, a, w, i[2], 9'h083, w, 3'h0);
			if (i[2]) st[7:5] = w[7:5];
			st[2:0] = e[2:0];
			#1 chk_st(8'hff);
			chk(i_sfb_core_model.res_seen, e[10:3], "alu");
		end
		$display("alu test done");
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		st = 8'h18;
		#1 chk_st(8'hff);
		$display("second reset test done");
		give_verdict();
	end
endmodule // status_flags_bank_select_bench
